// >>> core/cic_core_interrupt_control.sv
/*
  cic_core_interrupt_control: twelve flag/enable pairs, global and
  peripheral-group gating, the vectoring sequence, external pin edge
  detect, sleep wake and return-from-irq handling.
  Assumes one clock, a synchronous active-high reset, a core that
  honours flush/push/load and pops the stack itself on return_from_irq.
*/
`timescale 1ns/100ps
`default_nettype none
module cic_core_interrupt_control
  import cic_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        ce_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  input  wire cic_events_t ev_in,
  input  wire logic        ext_pin_in,
  input  wire logic [12:0] pc_in,
  input  wire logic        return_from_irq_in,
  input  wire logic        sleep_in,
  output cic_core_t        core_out,
  output logic      [1:0]  phase_out
);

  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  pen1_r;
  logic        pen2_r;
  logic [7:0]  pfl1_r;
  logic [7:0]  pfl1_nxt;
  logic        pfl2_r;
  logic        pfl2_nxt;
  logic        edge_sel_r;
  logic [1:0]  phase_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_s3_r;
  logic        ext_edge;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        wake_hold_r;
  cic_state_t  state_r;
  cic_core_t   core_r;
  logic        bus_req;
  logic        wr_en;
  logic        periph_req;
  logic        pend;
  logic        glob_en_eff;
  logic        take;

  // address match for one register; the low byte lane is checked in wr_en, not here
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr == off);
  endfunction

  // a write lands on the edge at which the master sees ack, where a classic cycle ends
  assign bus_req    = wb_cyc_in & wb_stb_in & ~ack_r;
  assign wr_en      = wb_cyc_in & wb_stb_in & ack_r & wb_we_in & wb_sel_in[0] & ce_in;
  assign wb_ack_out = ack_r;
  assign wb_dat_out = rdat_r;
  assign core_out   = core_r;
  assign phase_out  = phase_r;

  // instruction-cycle phase, Q1..Q4
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      phase_r <= PH_Q1;
    end else if (ce_in) begin
      phase_r <= phase_r + PH_STEP;
    end
  end

  // pin is asynchronous: two flops, then a third for the edge compare
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ext_s1_r <= RST_BIT;
      ext_s2_r <= RST_BIT;
      ext_s3_r <= RST_BIT;
    end else if (ce_in) begin
      ext_s1_r <= ext_pin_in;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // edge pick by ext_edge_select
  assign ext_edge = edge_sel_r ? (ext_s2_r & ~ext_s3_r) : (~ext_s2_r & ext_s3_r);

  // pending level, group enable gates the periph pairs
  assign periph_req = ctrl_r[B_GROUP_EN] & ((|(pen1_r & pfl1_r)) | (pen2_r & pfl2_r));
  assign pend = (ctrl_r[B_T0E] & ctrl_r[B_T0F])
              | (ctrl_r[B_PIN_EN] & ctrl_r[B_PIN_FLG])
              | (ctrl_r[B_RBE] & ctrl_r[B_RBF])
              | periph_req;

  // a return in this cycle already counts as enabled
  assign glob_en_eff = ctrl_r[B_GLOB_EN] | return_from_irq_in;

  // sampled once per instruction cycle at Q1, whatever instruction runs;
  // the core aborts a two-cycle instruction, so latency stays fixed
  assign take = ce_in & (state_r == ST_RUN) & (phase_r == PH_Q1) & glob_en_eff
              & pend & ~sleep_in & ~wake_hold_r;

  // control register: software write, then hardware, sets win over clears, except take clearing the global enable over a return
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (wr_en && hit(wb_adr_in, ADR_CTRL)) begin
      ctrl_nxt = wb_dat_in[7:0];
    end
    if (return_from_irq_in) begin
      ctrl_nxt[B_GLOB_EN] = 1'b1;
    end
    if (take) begin
      ctrl_nxt[B_GLOB_EN] = 1'b0;
    end
    if (ev_in.timer0) begin
      ctrl_nxt[B_T0F] = 1'b1;
    end
    if (ext_edge) begin
      ctrl_nxt[B_PIN_FLG] = 1'b1;
    end
    if (ev_in.port_change) begin
      ctrl_nxt[B_RBF] = 1'b1;
    end
  end

  // peripheral flags, events set them regardless of enables
  always_comb begin
    pfl1_nxt = pfl1_r;
    pfl2_nxt = pfl2_r;
    if (wr_en && hit(wb_adr_in, ADR_PFL1)) begin
      pfl1_nxt = wb_dat_in[7:0];
    end
    if (wr_en && hit(wb_adr_in, ADR_PFL2)) begin
      pfl2_nxt = wb_dat_in[B_CCP2];
    end
    pfl1_nxt = pfl1_nxt | ev_in.periph1;
    pfl2_nxt = pfl2_nxt | ev_in.periph2;
  end

  // all enables and flags clear on any reset
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ctrl_r <= RST_BYTE;
      pfl1_r <= RST_BYTE;
      pfl2_r <= RST_BIT;
    end else if (ce_in) begin
      ctrl_r <= ctrl_nxt;
      pfl1_r <= pfl1_nxt;
      pfl2_r <= pfl2_nxt;
    end
  end

  // enable and edge configuration registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pen1_r     <= RST_BYTE;
      pen2_r     <= RST_BIT;
      edge_sel_r <= RST_BIT;
    end else if (wr_en) begin
      if (hit(wb_adr_in, ADR_PEN1)) begin
        pen1_r <= wb_dat_in[7:0];
      end
      if (hit(wb_adr_in, ADR_PEN2)) begin
        pen2_r <= wb_dat_in[B_CCP2];
      end
      if (hit(wb_adr_in, ADR_EDGE)) begin
        edge_sel_r <= wb_dat_in[B_EDGE];
      end
    end
  end

  // bus answer one clock after the request; unmapped reads give zero
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ack_r  <= RST_BIT;
      rdat_r <= RD_ZERO;
    end else if (ce_in) begin
      ack_r  <= bus_req;
      rdat_r <= RD_ZERO;
      if (bus_req) begin
        unique case (wb_adr_in)
          ADR_CTRL: rdat_r[7:0] <= ctrl_r;
          ADR_PEN1: rdat_r[7:0] <= pen1_r;
          ADR_PEN2: rdat_r[B_CCP2] <= pen2_r;
          ADR_PFL1: rdat_r[7:0] <= pfl1_r;
          ADR_PFL2: rdat_r[B_CCP2] <= pfl2_r;
          ADR_EDGE: rdat_r[B_EDGE] <= edge_sel_r;
          default:  rdat_r <= RD_ZERO;
        endcase
      end
    end
  end

  // wake is not gated by the global enable; the flag and that enable decide
  // whether the core vectors afterwards
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      wake_hold_r <= RST_BIT;
    end else if (ce_in) begin
      if (sleep_in && pend) begin
        wake_hold_r <= 1'b1;
      end else if (!sleep_in && phase_r == PH_Q1) begin
        wake_hold_r <= 1'b0; // instruction after sleep runs this cycle
      end
    end
  end

  // vectoring: flush in the take cycle, push and load at its Q4,
  // fetch the vector next cycle, execute the cycle after
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_r <= ST_RUN;
    end else if (ce_in) begin
      unique case (state_r)
        ST_RUN: begin
          if (take) begin
            state_r <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          if (phase_r == PH_Q4) begin
            state_r <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (phase_r == PH_Q4) begin
            state_r <= ST_RUN;
          end
        end
      endcase
    end
  end

  // core commands; only the pc is pushed, the upper latch is never
  // touched here, so software must save it
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      core_r <= '0;
    end else if (ce_in) begin
      core_r.flush  <= take;
      core_r.push   <= (state_r == ST_FLUSH) && (phase_r == PH_Q4);
      core_r.load   <= (state_r == ST_FLUSH) && (phase_r == PH_Q4);
      core_r.wake   <= sleep_in & pend;
      core_r.vector <= IRQ_VECTOR;
      if (take) begin
        core_r.push_pc <= pc_in;
      end
    end
  end

  // sequences of the vectoring steps
  sequence s_enter;
    take ##1 (core_r.flush && !ctrl_r[B_GLOB_EN]);
  endsequence

  sequence s_call;
    ##3 (core_r.push && core_r.load && core_r.vector == IRQ_VECTOR);
  endsequence

  property p_reset_off;
    @(posedge mclk_in) reset_in |=> (ctrl_r == RST_BYTE && pen1_r == RST_BYTE && !pen2_r);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enables not clear after reset");

  property p_take_push;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      take |=> (state_r == ST_FLUSH && core_r.flush && core_r.push_pc == $past(pc_in));
  endproperty
  a_take_push: assert property (p_take_push) else $error("take did not save the pc");

  property p_periph_group;
    @(posedge mclk_in) disable iff (reset_in)
      (!ctrl_r[B_GROUP_EN] && !(ctrl_r[B_T0E] && ctrl_r[B_T0F]) && !(ctrl_r[B_PIN_EN]
        && ctrl_r[B_PIN_FLG]) && !(ctrl_r[B_RBE] && ctrl_r[B_RBF])) |-> !take;
  endproperty
  a_periph_group: assert property (p_periph_group) else $error("periph taken ungated");

  property p_flag_set;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      ev_in.timer0 |=> ctrl_r[B_T0F];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("timer0 flag lost");

  property p_vector_seq;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      s_enter |-> s_call;
  endproperty
  a_vector_seq: assert property (p_vector_seq) else $error("vector sequence wrong");

  property p_no_take_off;
    @(posedge mclk_in) disable iff (reset_in)
      (!ctrl_r[B_GLOB_EN] && !return_from_irq_in) |-> !take;
  endproperty
  a_no_take_off: assert property (p_no_take_off) else $error("taken with enable clear");

  property p_return;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (return_from_irq_in && !take) |=> ctrl_r[B_GLOB_EN];
  endproperty
  a_return: assert property (p_return) else $error("return did not enable");

  property p_latency;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      take |-> ##8 (state_r == ST_RUN && phase_r == PH_Q1);
  endproperty
  a_latency: assert property (p_latency) else $error("vector not reached in time");

  property p_ext_edge;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (edge_sel_r && $rose(ext_s2_r) && $stable(edge_sel_r)) |=> ctrl_r[B_PIN_FLG];
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("rising edge missed");

  property p_after_sleep;
    @(posedge mclk_in) disable iff (reset_in)
      $fell(sleep_in) |-> !take;
  endproperty
  a_after_sleep: assert property (p_after_sleep) else $error("vectored before next op");

  property p_pin_fall;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (!edge_sel_r && $fell(ext_s2_r) && $stable(edge_sel_r)) |=> ctrl_r[B_PIN_FLG];
  endproperty
  a_pin_fall: assert property (p_pin_fall) else $error("falling edge missed");

  property p_wake;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (sleep_in && pend) |=> core_r.wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake while pending in sleep");

  property p_bus_answer;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus request not answered");

  property p_write_at_ack;
    @(posedge mclk_in) disable iff (reset_in || !ce_in)
      (wr_en && hit(wb_adr_in, ADR_PEN1)) |=> (pen1_r == $past(wb_dat_in[7:0]));
  endproperty
  a_write_at_ack: assert property (p_write_at_ack) else $error("enable write lost");

endmodule
`default_nettype wire

// >>> core/cic_pkg.sv
/*
  cic_pkg: constants and carrier types of the core interrupt control block.
  Assumes byte addressing on a 32-bit classic Wishbone bus and a core that
  runs one instruction cycle per four clocks, phase Q1 first.
*/
package cic_pkg;

  // register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00; // irq_control_reg
  localparam logic [7:0] ADR_PEN1 = 8'h04; // periph_enable_reg_1
  localparam logic [7:0] ADR_PEN2 = 8'h08; // periph_enable_reg_2
  localparam logic [7:0] ADR_PFL1 = 8'h0c; // periph_flag_reg_1
  localparam logic [7:0] ADR_PFL2 = 8'h10; // periph_flag_reg_2
  localparam logic [7:0] ADR_EDGE = 8'h14; // edge configuration

  // irq_control_reg field positions
  localparam int B_GLOB_EN  = 7;
  localparam int B_GROUP_EN = 6;
  localparam int B_T0E      = 5;
  localparam int B_PIN_EN   = 4;
  localparam int B_RBE      = 3;
  localparam int B_T0F      = 2;
  localparam int B_PIN_FLG  = 1;
  localparam int B_RBF      = 0;
  localparam int B_EDGE = 0; // ext_edge_select in edge configuration
  localparam int B_CCP2 = 0; // only bit of the second periph pair

  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic        RST_BIT  = 1'b0;
  localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

  // vector and instruction-cycle phases
  localparam logic [12:0] IRQ_VECTOR = 13'h0004;
  localparam logic [1:0]  PH_Q1      = 2'h0;
  localparam logic [1:0]  PH_Q4      = 2'h3;
  localparam logic [1:0]  PH_STEP    = 2'h1;

  // vectoring sequence, one-hot
  typedef enum logic [2:0] {
    ST_RUN   = 3'b001,
    ST_FLUSH = 3'b010,
    ST_FETCH = 3'b100
  } cic_state_t;

  // synchronous event pulses from the peripherals
  typedef struct packed {
    logic       timer0;
    logic       port_change;
    logic [7:0] periph1;
    logic       periph2;
  } cic_events_t;

  // commands to the core sequencer
  typedef struct packed {
    logic        flush;
    logic        push;
    logic        load;
    logic        wake;
    logic [12:0] push_pc;
    logic [12:0] vector;
  } cic_core_t;

endpackage

// >>> testbench/cic_core_model.sv
/*
  cic_core_model: behavioural core sequencer on the far side of the block.
  Assumes the block's core_out commands and a one-deep return stack.
*/
`timescale 1ns/100ps
`default_nettype none
module cic_core_model
  import cic_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire cic_core_t   core_in,
  input  wire logic        ret_req_in,
  output logic      [12:0] pc_out,
  output logic             ret_out
);
  // working registers are the service routine's to save
  logic [12:0] stack_r;

  // pc stands still between commands so a pushed value is predictable
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pc_out  <= 13'h0123;
      stack_r <= 13'h0000;
      ret_out <= 1'b0;
    end else begin
      ret_out <= ret_req_in;
      if (core_in.push) begin
        stack_r <= core_in.push_pc; // only the pc is kept
      end
      if (core_in.load) begin
        pc_out <= core_in.vector; // jump to vector
      end else if (ret_req_in) begin
        pc_out <= stack_r; // pop on return
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/test_cic_core_interrupt_control.sv
/*
  test_cic_core_interrupt_control: self-checking bench of the irq block.
  Assumes cic_core_model as the core and one 250 MHz clock.
*/
`timescale 1ns/100ps
`default_nettype none
module test_cic_core_interrupt_control
  import cic_pkg::*;
;
  logic        mclk_in;
  logic        reset_in;
  logic        cyc;
  logic        we;
  logic        ext_pin;
  logic        ret_req;
  logic        ret_pulse;
  logic        sleep;
  logic        ce;
  logic [1:0]  phase;
  logic [1:0]  ph;
  logic        ack;
  logic        got;
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [12:0] pc;
  logic [12:0] pushed;
  logic [12:0] vec;
  cic_events_t ev;
  cic_core_t   core;
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;

  cic_core_interrupt_control dut_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .ce_in(ce),
    .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(4'h1), .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .ev_in(ev), .ext_pin_in(ext_pin), .pc_in(pc),
    .return_from_irq_in(ret_pulse), .sleep_in(sleep), .core_out(core),
    .phase_out(phase)
  );

  cic_core_model core_u (
    .mclk_in(mclk_in), .reset_in(reset_in), .core_in(core),
    .ret_req_in(ret_req), .pc_out(pc), .ret_out(ret_pulse)
  );

  task end_sim;
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // classic cycle: held until ack is sampled, data taken at that edge
  task wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= {24'h00_0000, d};
    do @(posedge mclk_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk($sformatf("reg %h", a), q, e);
  endtask

  // watch n clocks for flush followed by push and load
  task wait_load(input int n);
    logic fl;
    fl  = 1'b0;
    got = 1'b0;
    repeat (n) begin
      @(posedge mclk_in);
      if (core.flush === 1'b1) fl = 1'b1;
      if (core.load === 1'b1 && core.push === 1'b1 && fl) begin
        got    = 1'b1;
        pushed = core.push_pc;
        vec    = core.vector;
      end
    end
  endtask

  task pulse(input logic [10:0] e);
    @(posedge mclk_in);
    ev <= cic_events_t'(e);
    @(posedge mclk_in);
    ev <= '0;
  endtask

  task ret;
    @(posedge mclk_in);
    ret_req <= 1'b1;
    @(posedge mclk_in);
    ret_req <= 1'b0;
  endtask

  // all registers clear, the unmapped slot at 18 included; the phase
  // steps each clock, and a low clock enable keeps an event out
  task t_reset;
    for (int i = 0; i < 7; i++) rd(8'(4 * i), 32'h0000_0000); // cleared
    ph = phase;
    @(posedge mclk_in);
    chk("phase", 32'(phase), 32'(2'(ph + PH_STEP)));
    ce <= 1'b0;
    pulse(11'h400);
    ce <= 1'b1;
    rd(ADR_CTRL, 32'h0000_0000); // frozen, still clear
  endtask

  // every event sets its flag with all enables off
  task t_flags;
    pulse(11'h7ff);
    rd(ADR_CTRL, 32'h0000_0005); // core flags
    rd(ADR_PFL1, 32'h0000_00ff); // periph flags
    rd(ADR_PFL2, 32'h0000_0001); // twelfth flag
  endtask

  // group gate, take sequence, return with one flag left pending
  task t_gate_ret;
    wr(ADR_PEN1, 8'hff);
    wr(ADR_PEN2, 8'h01);
    wr(ADR_CTRL, 8'h80);
    wait_load(16);
    chk("take", 32'(got), 32'h0000_0000); // group gate off
    wr(ADR_CTRL, 8'hc0);
    wait_load(12);
    chk("take", 32'(got), 32'h0000_0001); // gated pairs
    chk("push", 32'(pushed), 32'h0000_0123); // pc saved
    chk("vector", 32'(vec), 32'h0000_0004); // vector load
    rd(ADR_CTRL, 32'h0000_0040); // global off
    wr(ADR_PFL1, 8'h00);
    ret;
    wait_load(12);
    chk("retake", 32'(got), 32'h0000_0001); // flag left
    rd(ADR_CTRL, 32'h0000_0040); // global stays off
    wr(ADR_PFL2, 8'h00); // serviced flag cleared
    ret;
    rd(ADR_CTRL, 32'h0000_00c0); // global back on
    chk("pc", 32'(pc), 32'h0000_0123); // popped pc
  endtask

  // synchronous source: timer0 reaches the vector in three cycles
  task t_sync;
    wr(ADR_CTRL, 8'ha0);
    pulse(11'h400);
    wait_load(11);
    chk("latency", 32'(got), 32'h0000_0001); // three cycles
    rd(ADR_CTRL, 32'h0000_0024); // flag kept
    wr(ADR_CTRL, 8'h20);
    ret;
  endtask

  // both edge selections, then redirect only with the pin enable
  task t_pin;
    for (int s = 1; s >= 0; s--) begin
      wr(ADR_EDGE, 8'(s));
      ext_pin <= !s[0];
      repeat (8) @(posedge mclk_in);
      wr(ADR_CTRL, 8'h00);
      ext_pin <= s[0];
      repeat (8) @(posedge mclk_in);
      rd(ADR_CTRL, 32'h0000_0002); // selected edge
      wr(ADR_CTRL, 8'h00);
      ext_pin <= !s[0];
      repeat (8) @(posedge mclk_in);
      rd(ADR_CTRL, 32'h0000_0000); // other edge ignored
    end
    wr(ADR_CTRL, 8'h80);
    ext_pin <= 1'b0;
    wait_load(16);
    chk("pin take", 32'(got), 32'h0000_0000); // pin enable off
    wr(ADR_CTRL, 8'h90);
    ext_pin <= 1'b1;
    repeat (8) @(posedge mclk_in);
    ext_pin <= 1'b0;
    wait_load(16);
    chk("pin take", 32'(got), 32'h0000_0001); // async latency
  endtask

  // wake with global enable clear, then service on re-enable
  task t_sleep;
    wr(ADR_CTRL, 8'h20); // enable set before sleep
    sleep <= 1'b1;
    pulse(11'h400);
    repeat (3) @(posedge mclk_in);
    chk("wake", 32'(core.wake), 32'h0000_0001); // wake request
    sleep <= 1'b0;
    wait_load(16);
    chk("take", 32'(got), 32'h0000_0000); // falls through
    wr(ADR_CTRL, 8'ha4);
    wait_load(12);
    chk("take", 32'(got), 32'h0000_0001); // pending served
  endtask

  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end

  // hang guard, well above the few hundred clocks the run needs
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      end_sim;
    end
  end

  initial begin
    reset_in = 1'b1;
    cyc      = 1'b0;
    we       = 1'b0;
    adr      = 8'h00;
    dat      = 32'h0000_0000;
    ev       = '0;
    ext_pin  = 1'b0;
    ret_req  = 1'b0;
    sleep    = 1'b0;
    ce       = 1'b1;
    repeat (10) @(posedge mclk_in);
    reset_in <= 1'b0;
    t_reset;
    t_flags;
    t_gate_ret;
    t_sync;
    t_pin;
    t_sleep;
    end_sim;
  end
endmodule
`default_nettype wire
